/* testbench/sercon_dev_model.sv */
// Purpose: Behavioural model of the encoder's two-wire control port slave.
// Assumes: Wired line levels are formed outside; the model only pulls data low.
// Notes:   slow_i delays every answer; deaf_i refuses the device address.
`timescale 1ns/1ps
module sercon_dev_model #(
  parameter logic [6:0] DEV_ADDR = 7'h75
) (
  // Wired line levels
  input  wire logic scl_i,
  input  wire logic sda_i,
  // Behaviour controls
  input  wire logic slow_i,
  input  wire logic deaf_i,
  // Data pull-down; there is no clock output at all
  output logic      sda_oe_o
);
  typedef enum logic [2:0] {P_IDLE, P_DAB, P_RAB, P_WR, P_RD} dev_phase_t;
  logic [7:0] mem [64];
  logic [7:0] sh;
  logic [7:0] tx;
  logic [5:0] ptr;
  logic       step;
  logic       first;
  logic       acked;
  int         bitc;
  dev_phase_t ph;
  initial begin
    sda_oe_o = 1'b0;
    ph = P_IDLE;
    bitc = 0;
    foreach (mem[i]) mem[i] = 8'h00;
  end
  // A data edge counts only if it still stands 5 ns on, so only the trailing edge of a shorter spike can start or stop a frame.
  always @(negedge sda_i) begin
    #5;
    if (sda_i === 1'b0 && scl_i === 1'b1) begin
      ph = P_DAB;
      bitc = -1;
      sda_oe_o = 1'b0;
    end
  end
  always @(posedge sda_i) begin
    #5;
    if (sda_i === 1'b1 && scl_i === 1'b1) begin
      ph = P_IDLE;
      sda_oe_o = 1'b0;
    end
  end
  // Data is taken on the rising clock edge only, so changes while high never count.
  always @(posedge scl_i) begin
    if (bitc < 8) sh = {sh[6:0], sda_i};
    else acked = !sda_i;
  end
  always @(negedge scl_i) begin
    if (slow_i) #100;
    if (ph != P_IDLE && bitc == 7) begin
      bitc = 8;
      sda_oe_o = 1'b0;
      case (ph)
        P_DAB: if (!deaf_i && sh[7:1] == DEV_ADDR) sda_oe_o = 1'b1; else ph = P_IDLE;
        P_RAB: begin
          ptr = sh[5:0];
          step = sh[6];
          first = 1'b1;
          sda_oe_o = 1'b1;
        end
        P_WR: begin
          if (step && ptr == 6'h3f) begin
            ptr = sh[5:0];
          end else begin
            mem[ptr] = sh;
            if (step) ptr = ptr + 6'h01;
          end
          sda_oe_o = 1'b1;
        end
        default: ;
      endcase
    end else if (ph != P_IDLE && bitc == 8) begin
      bitc = 0;
      sda_oe_o = 1'b0;
      case (ph)
        P_DAB: ph = sh[0] ? P_RD : P_RAB;
        P_RAB: ph = P_WR;
        P_WR: if (!step) ph = P_RAB;
        P_RD: if (!acked) ph = P_IDLE;
        default: ;
      endcase
      if (ph == P_RD) begin
        if (step && !first) ptr = (ptr == 6'h2a) ? 6'h00 : ptr + 6'h01;
        first = 1'b0;
        tx = mem[ptr];
        sda_oe_o = !tx[7];
      end
    end else if (ph != P_IDLE) begin
      bitc++;
      if (ph == P_RD) sda_oe_o = !tx[7-bitc];
    end
  end
endmodule

/* testbench/sercon_host_asserts.sv */
// Purpose: Port-level checks on the two-wire control port host.
// Assumes: QUARTER of 4 or more, so a data change never lands within a clock edge window.
// Notes:   Lines are open-drain; an output enable high means that line is pulled low.
`timescale 1ns/1ps
module sercon_host_asserts #(
  parameter int QUARTER = 4
) (
  input wire logic                              core_clk_i,
  input wire logic                              resetn_i,
  input wire logic [sercon_pkg::REG_ADDR_W-1:0] reg_addr_i,
  input wire logic [7:0]                        reg_wdata_i,
  input wire logic                              reg_wr_i,
  input wire logic                              reg_rd_i,
  input wire logic [7:0]                        reg_rdata_o,
  input wire logic                              serial_clock_pin_i,
  input wire logic                              serial_clock_pin_o,
  input wire logic                              serial_clock_pin_oe_o,
  input wire logic                              serial_data_pin_i,
  input wire logic                              serial_data_pin_o,
  input wire logic                              serial_data_pin_oe_o
);
  localparam int QB = QUARTER;
  localparam int PULSE_MAX = 2 * QUARTER + 2;
  logic [7:0] run_len;
  default clocking dc @(posedge core_clk_i); endclocking
  default disable iff (!resetn_i);
  // Saturating length of the present clock-enable level, so idle gaps count as long.
  always_ff @(posedge core_clk_i) begin
    if (!resetn_i) begin
      run_len <= 8'hff;
    end else if ($changed(serial_clock_pin_oe_o)) begin
      run_len <= 8'h01;
    end else if (run_len != 8'hff) begin
      run_len <= run_len + 8'h01;
    end
  end
  property p_reset;
    @(posedge core_clk_i) disable iff (1'b0)
      !resetn_i |=> !serial_clock_pin_oe_o && !serial_data_pin_oe_o;
  endproperty
  property p_pins; serial_data_pin_oe_o |-> !serial_data_pin_o && !serial_clock_pin_o; endproperty
  property p_start;
    $rose(serial_data_pin_oe_o) && !serial_clock_pin_oe_o
      |-> serial_data_pin_oe_o throughout (##[1:QB] $rose(serial_clock_pin_oe_o));
  endproperty
  property p_stop;
    $fell(serial_data_pin_oe_o) && !serial_clock_pin_oe_o
      |-> (!serial_clock_pin_oe_o && !serial_data_pin_oe_o) [*8];
  endproperty
  property p_data; $changed(serial_data_pin_oe_o) |-> serial_clock_pin_oe_o || run_len >= QB;
  endproperty
  property p_rate; $changed(serial_clock_pin_oe_o) |-> run_len >= 2 * QB; endproperty
  property p_pulse;
    $rose(serial_clock_pin_oe_o) |-> ##[1:PULSE_MAX] $fell(serial_clock_pin_oe_o);
  endproperty
  property p_rdata; !$past(reg_rd_i) |-> reg_rdata_o == 8'h00; endproperty
  a_reset: assert property (p_reset) else $error("lines not released in reset");
  a_pins: assert property (p_pins) else $error("pin output driven high");
  a_start: assert property (p_start) else $error("start not followed by clock pull");
  a_stop: assert property (p_stop) else $error("lines not idle after stop");
  a_data: assert property (p_data) else $error("data changed early in clock high");
  a_rate: assert property (p_rate) else $error("clock phase too short");
  a_pulse: assert property (p_pulse) else $error("clock held low too long");
  a_rdata: assert property (p_rdata) else $error("read data outside its cycle");
  c_start: cover property ($rose(serial_data_pin_oe_o) && !serial_clock_pin_oe_o);
  c_stop: cover property ($fell(serial_data_pin_oe_o) && !serial_clock_pin_oe_o);
  c_read: cover property (reg_rd_i ##1 reg_rdata_o != 8'h00);
endmodule
bind sercon_host sercon_host_asserts #(.QUARTER(QUARTER)) chk_i (
  .core_clk_i, .resetn_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i, .reg_rdata_o,
  .serial_clock_pin_i, .serial_clock_pin_o, .serial_clock_pin_oe_o,
  .serial_data_pin_i, .serial_data_pin_o, .serial_data_pin_oe_o);

/* testbench/sercon_host_tb.sv */
// Purpose: Self-checking bench for the two-wire control port host.
// Assumes: QUARTER shortened to 4 so frames stay short.
// Notes:   Device registers are checked by the bench, reading the slave model's memory.
`timescale 1ns/1ps
module sercon_host_tb;
  import sercon_pkg::*;
  localparam int Q = 4;
  logic       core_clk_i, resetn_i, reg_wr_i, reg_rd_i;
  logic [3:0] reg_addr_i;
  logic [7:0] reg_wdata_i, reg_rdata_o;
  logic       scl_o, scl_oe, sda_o, sda_oe, dev_oe, slow, deaf;
  wire        scl_line = !scl_oe;
  wire        sda_line = !(sda_oe || dev_oe);
  int         miscompares = 0;
  int         tests_run = 0;
  sercon_host #(.QUARTER(Q)) uut (
    .core_clk_i, .resetn_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i, .reg_rdata_o,
    .serial_clock_pin_i(scl_line), .serial_clock_pin_o(scl_o), .serial_clock_pin_oe_o(scl_oe),
    .serial_data_pin_i(sda_line), .serial_data_pin_o(sda_o), .serial_data_pin_oe_o(sda_oe));
  sercon_dev_model #(.DEV_ADDR(DEV_ADDR_DEFAULT)) dev (
    .scl_i(scl_line), .sda_i(sda_line), .slow_i(slow), .deaf_i(deaf), .sda_oe_o(dev_oe));
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    tests_run++;
    if (got !== exp) begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge core_clk_i);
    reg_addr_i  <= a;
    reg_wdata_i <= d;
    reg_wr_i    <= 1'b1;
    @(posedge core_clk_i);
    reg_wr_i    <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge core_clk_i);
    reg_addr_i <= a;
    reg_rd_i   <= 1'b1;
    @(posedge core_clk_i);
    reg_rd_i   <= 1'b0;
    #1;
    d = reg_rdata_o;
  endtask
  // Starts a transfer, polls until idle, checks the final status and clears it.
  task automatic run(input logic [7:0] ctrl, input logic [5:0] p, input logic [7:0] n,
                     input logic [7:0] fin);
    logic [7:0] s;
    wr(REG_PTR, {2'b00, p});
    wr(REG_COUNT, n);
    wr(REG_CTRL, ctrl);
    rd(REG_STATUS, s);
    chk("busy", 8'h01, s);
    for (int i = 0; i < 4000 && s[STAT_BUSY_BIT] !== 1'b0; i++) rd(REG_STATUS, s);
    chk("status", fin, s);
    wr(REG_STATUS, 8'h06);
  endtask
  task automatic t_reset();
    logic [7:0] v;
    chk("line_oe", 8'h00, {6'h00, scl_oe, sda_oe});
    chk("pin_out", 8'h00, {6'h00, scl_o, sda_o});
    rd(REG_STATUS, v);
    chk("status", 8'h00, v);
    rd(4'h5, v);
    chk("unmapped", 8'h00, v);
    // Go with a zero count must not start a frame; a large count clamps to the buffer depth.
    wr(REG_CTRL, 8'h01);
    rd(REG_STATUS, v);
    chk("go_count0", 8'h00, v);
    wr(REG_COUNT, 8'h0f);
    rd(REG_COUNT, v);
    chk("count_clamp", {4'h0, BUF_DEPTH_CNT}, v);
  endtask
  // Auto write from 3d crosses the address-register location.
  task automatic t_auto_write();
    logic [7:0] v;
    for (int i = 0; i < 4; i++) wr(4'h8 + 4'(i), 8'ha1 + 8'(i));
    run(8'h05, 6'h3d, 8'h04, 8'h02);
    chk("reg3d", 8'ha1, dev.mem[6'h3d]);
    chk("reg3e", 8'ha2, dev.mem[6'h3e]);
    chk("reg3f", 8'h00, dev.mem[6'h3f]);
    chk("reg00", 8'ha3, dev.mem[6'h00]);
    chk("reg01", 8'ha4, dev.mem[6'h01]);
    rd(REG_PTR, v);
    chk("ptr", 8'h02, v);
    rd(REG_CTRL, v);
    chk("ctrl", 8'h04, v);
  endtask
  task automatic t_auto_read();
    logic [7:0] v;
    dev.mem[6'h29] = 8'h5c;
    dev.mem[6'h2a] = 8'h3b;
    run(8'h07, 6'h29, 8'h03, 8'h02);
    rd(4'h8, v);
    chk("buf0", 8'h5c, v);
    rd(4'h9, v);
    chk("buf1", 8'h3b, v);
    rd(4'ha, v);
    chk("buf2", 8'ha3, v);
  endtask
  // Alternating mode both ways, with the device answering late.
  task automatic t_alt();
    logic [7:0] v;
    slow = 1'b1;
    wr(4'h8, 8'h66);
    wr(4'h9, 8'h99);
    run(8'h01, 6'h10, 8'h02, 8'h02);
    chk("reg10", 8'h66, dev.mem[6'h10]);
    chk("reg11", 8'h99, dev.mem[6'h11]);
    dev.mem[6'h12] = 8'h7e;
    run(8'h03, 6'h11, 8'h02, 8'h02);
    rd(4'h8, v);
    chk("buf0", 8'h99, v);
    rd(4'h9, v);
    chk("buf1", 8'h7e, v);
    slow = 1'b0;
  endtask
  task automatic t_nack();
    deaf = 1'b1;
    run(8'h01, 6'h05, 8'h01, 8'h06);
    chk("reg05", 8'h00, dev.mem[6'h05]);
    deaf = 1'b0;
  endtask
  task automatic end_sim();
    $display("checks %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  initial begin
    core_clk_i = 1'b0;
    forever #20 core_clk_i = ~core_clk_i;
  end
  initial begin
    resetn_i = 1'b0;
    reg_wr_i = 1'b0;
    reg_rd_i = 1'b0;
    reg_addr_i = 4'h0;
    reg_wdata_i = 8'h00;
    slow = 1'b0;
    deaf = 1'b0;
    repeat (3) @(posedge core_clk_i);
    resetn_i <= 1'b1;
    t_reset();
    t_auto_write();
    t_auto_read();
    t_alt();
    t_nack();
    end_sim();
  end
  // Five short frames take well under ten thousand cycles; this margin only cuts a hang.
  initial begin
    repeat (60000) @(posedge core_clk_i);
    miscompares++;
    end_sim();
  end
endmodule

/* verilog/pin_sync.sv */
// Purpose: Three-stage synchroniser with agreement filter for pin inputs.
// Assumes: Pins rest high, so the filtered value starts high.
// Notes:   A change is taken only once the second and third stages agree.

`timescale 1ns/1ps

module pin_sync #(
  parameter int WIDTH = 2
) (
  // Clock and reset
  input  wire logic             core_clk_i,
  input  wire logic             resetn_i,
  // Pins and filtered levels
  input  wire logic [WIDTH-1:0] pins_i,
  output logic      [WIDTH-1:0] pins_o
);

  typedef struct packed {
    logic [WIDTH-1:0] s1;
    logic [WIDTH-1:0] s2;
    logic [WIDTH-1:0] s3;
    logic [WIDTH-1:0] val;
  } sync_t;

  sync_t r;
  sync_t next_r;

  always_comb begin
    next_r     = r;
    next_r.s1  = pins_i;
    next_r.s2  = r.s1;
    next_r.s3  = r.s2;
    next_r.val = (r.s2 & ~(r.s2 ^ r.s3)) | (r.val & (r.s2 ^ r.s3));
  end

  always_ff @(posedge core_clk_i) begin
    if (!resetn_i) begin
      r <= '1;
    end else begin
      r <= next_r;
    end
  end

  assign pins_o = r.val;

endmodule

/* verilog/sercon_host.sv */
// Purpose: Host-side master for the two-wire control port of the video encoder.
// Assumes: The device is the only slave; software loads pointer, count and buffer first.
// Notes:   Both lines are open-drain; the host pulls low or releases, never drives high.

`timescale 1ns/1ps

// Function
// - The host generates every clock pulse on the serial clock line.
// - Both lines are released and rest high whenever no transfer runs.
// - Lines are only pulled low or released, giving a wired-AND.
// - Bit rate stays at or below 400 kbit/s.
// - Start: data falls while clock is high, restarting byte sequencing.
// - Stop: data rises while clock is high, returning to idle.
// - Data bits change only while the clock is low.
// - First byte after start is the device address with read/write flag.
// - After a write-direction address, the next byte is the register address.
// - Alternating mode sends a register address before every single access.
module sercon_host
  import sercon_pkg::*;
#(
  parameter logic [6:0] DEV_ADDR = sercon_pkg::DEV_ADDR_DEFAULT,
  parameter int         QUARTER  = sercon_pkg::QUARTER_CYCLES
) (
  // Clock and reset
  input  wire logic                              core_clk_i,
  input  wire logic                              resetn_i,
  // Command port
  input  wire logic [sercon_pkg::REG_ADDR_W-1:0] reg_addr_i,
  input  wire logic [7:0]                        reg_wdata_i,
  input  wire logic                              reg_wr_i,
  input  wire logic                              reg_rd_i,
  output logic      [7:0]                        reg_rdata_o,
  // Serial clock line
  input  wire logic                              serial_clock_pin_i,
  output logic                                   serial_clock_pin_o,
  output logic                                   serial_clock_pin_oe_o,
  // Serial data line
  input  wire logic                              serial_data_pin_i,
  output logic                                   serial_data_pin_o,
  output logic                                   serial_data_pin_oe_o
);

  import sercon_pkg::*;

  // ****************************************************************
  // Input conditioning and bit timing
  // ****************************************************************
  host_state_t r;
  host_state_t next_r;
  logic [1:0]  pins_s;
  logic        scl_s;
  logic        sda_s;
  logic        tick;
  logic        drive_bit;
  logic        stall;
  logic [5:0]  ptr_inc;
  logic [5:0]  ptr_rd;

  pin_sync #(
    .WIDTH (2)
  ) u_pin_sync (
    .core_clk_i (core_clk_i),
    .resetn_i   (resetn_i),
    .pins_i     ({serial_clock_pin_i, serial_data_pin_i}),
    .pins_o     (pins_s)
  );

  assign scl_s = pins_s[1];
  assign sda_s = pins_s[0];

  tick_gen #(
    .QUARTER (QUARTER)
  ) u_tick_gen (
    .core_clk_i (core_clk_i),
    .resetn_i   (resetn_i),
    .run_i      (r.st != ST_IDLE),
    .tick_o     (tick)
  );

  // ****************************************************************
  // Next-state logic
  // ****************************************************************
  always_comb begin
    next_r       = r;
    next_r.rdata = 8'h00;
    ptr_inc      = r.ptr + 6'h01;
    // Read pointer model: the next read lands one further, wrapping after the last location in step mode.
    ptr_rd       = (r.step && r.ptr == LAST_READ_LOC) ? 6'h00 : ptr_inc;
    // During the ack bit a transmitter releases; a receiver pulls low to acknowledge.
    if (r.rx) begin
      drive_bit = (r.bitn == ACK_BIT_INDEX) ? ~r.ack_out : 1'b1;
    end else begin
      drive_bit = (r.bitn == ACK_BIT_INDEX) ? 1'b1 : r.sh[7];
    end
    // A slow or held clock line stretches the high phase before sampling.
    stall = (r.q == 2'd2) && !scl_s;

    // Command port reads: data stands in the following cycle only.
    if (reg_rd_i) begin
      if (reg_addr_i[BUF_SEL_BIT]) begin
        next_r.rdata = r.bufm[reg_addr_i[2:0]];
      end else begin
        case (reg_addr_i)
          REG_CTRL:   next_r.rdata = {5'h00, r.step, r.rw, 1'b0};
          REG_PTR:    next_r.rdata = {2'b00, r.ptr};
          REG_COUNT:  next_r.rdata = {4'h0, r.count};
          REG_STATUS: next_r.rdata = {5'h00, r.nack, r.done, r.busy};
          default:    next_r.rdata = 8'h00;
        endcase
      end
    end

    // Command port writes; setup is locked while a transfer runs.
    if (reg_wr_i) begin
      if (reg_addr_i == REG_STATUS) begin
        if (reg_wdata_i[STAT_DONE_BIT]) begin
          next_r.done = 1'b0;
        end
        if (reg_wdata_i[STAT_NACK_BIT]) begin
          next_r.nack = 1'b0;
        end
      end else if (!r.busy) begin
        if (reg_addr_i[BUF_SEL_BIT]) begin
          next_r.bufm[reg_addr_i[2:0]] = reg_wdata_i;
        end else if (reg_addr_i == REG_PTR) begin
          next_r.ptr = reg_wdata_i[5:0];
        end else if (reg_addr_i == REG_COUNT) begin
          next_r.count = (reg_wdata_i[3:0] > BUF_DEPTH_CNT) ? BUF_DEPTH_CNT : reg_wdata_i[3:0];
        end else if (reg_addr_i == REG_CTRL) begin
          next_r.rw   = reg_wdata_i[CTRL_RW_BIT];
          next_r.step = reg_wdata_i[CTRL_STEP_BIT];
          if (reg_wdata_i[CTRL_GO_BIT] && r.count != 4'h0) begin
            next_r.busy = 1'b1;
            next_r.done = 1'b0;
            next_r.nack = 1'b0;
            next_r.st   = ST_START;
            next_r.q    = 2'd0;
            next_r.ph   = PH_DABW;
            next_r.rx   = 1'b0;
            next_r.sh   = make_dab(DEV_ADDR, 1'b0);
            next_r.idx  = 3'd0;
            next_r.left = r.count;
          end
        end
      end
    end

    // Line sequencer: each bit is four quarters, clock low in quarters 0 and 1.
    if (tick && !stall) begin
      next_r.q = r.q + 2'd1;
      unique case (r.st)
        ST_IDLE: begin
          next_r.q      = 2'd0;
          next_r.scl_oe = 1'b0;
          next_r.sda_oe = 1'b0;
        end
        ST_START: begin
          // Start and repeated start share one sequence.
          unique case (r.q)
            2'd0: next_r.sda_oe = 1'b0;
            2'd1: next_r.scl_oe = 1'b0;
            2'd2: next_r.sda_oe = 1'b1;
            2'd3: begin
              next_r.scl_oe = 1'b1;
              next_r.st     = ST_BIT;
              next_r.bitn   = 4'h0;
            end
          endcase
        end
        ST_STOP: begin
          unique case (r.q)
            2'd0: next_r.sda_oe = 1'b1;
            2'd1: next_r.scl_oe = 1'b0;
            2'd2: next_r.sda_oe = 1'b0;
            2'd3: begin
              next_r.st   = ST_IDLE;
              next_r.busy = 1'b0;
              next_r.done = 1'b1;
            end
          endcase
        end
        ST_BIT: begin
          unique case (r.q)
            2'd0: next_r.sda_oe = ~drive_bit;
            2'd1: next_r.scl_oe = 1'b0;
            2'd2: begin
              if (r.bitn == ACK_BIT_INDEX) begin
                next_r.acked = !sda_s;
              end else begin
                next_r.sh = {r.sh[6:0], r.rx ? sda_s : 1'b0};
              end
            end
            2'd3: begin
              next_r.scl_oe = 1'b1;
              if (r.bitn != ACK_BIT_INDEX) begin
                next_r.bitn = r.bitn + 4'h1;
              end else if (!r.rx && !r.acked) begin
                // No answer: give the line back with a stop and report it.
                next_r.nack = 1'b1;
                next_r.st   = ST_STOP;
              end else begin
                next_r.bitn = 4'h0;
                unique case (r.ph)
                  PH_DABW: begin
                    next_r.sh = make_rab(r.step, r.ptr);
                    next_r.ph = PH_RAB;
                  end
                  PH_RAB: begin
                    if (r.rw) begin
                      next_r.st = ST_START;
                      next_r.sh = make_dab(DEV_ADDR, 1'b1);
                      next_r.ph = PH_DABR;
                    end else begin
                      next_r.sh = r.bufm[r.idx];
                      next_r.ph = PH_DATAW;
                    end
                  end
                  PH_DATAW: begin
                    next_r.idx  = r.idx + 3'd1;
                    next_r.left = r.left - 4'h1;
                    next_r.ptr  = ptr_inc;
                    if (r.left == 4'h1) begin
                      next_r.st = ST_STOP;
                    end else if (!r.step) begin
                      next_r.sh = make_rab(1'b0, ptr_inc);
                      next_r.ph = PH_RAB;
                    end else if (ptr_inc == ADDR_REG_LOC) begin
                      // The device now takes the next byte as a start address.
                      next_r.ptr = 6'h00;
                      next_r.sh  = make_rab(1'b1, 6'h00);
                      next_r.ph  = PH_RAB;
                    end else begin
                      next_r.sh = r.bufm[r.idx + 3'd1];
                    end
                  end
                  PH_DABR: begin
                    next_r.rx      = 1'b1;
                    next_r.ph      = PH_DATAR;
                    next_r.ack_out = r.step && (r.left != 4'h1);
                  end
                  PH_DATAR: begin
                    // The byte just read came from r.ptr; the advance is for the next one.
                    next_r.bufm[r.idx] = r.sh;
                    next_r.idx         = r.idx + 3'd1;
                    next_r.left        = r.left - 4'h1;
                    next_r.ptr         = ptr_rd;
                    if (r.left == 4'h1) begin
                      next_r.rx = 1'b0;
                      next_r.st = ST_STOP;
                    end else if (r.step) begin
                      next_r.ack_out = (r.left != 4'h2);
                    end else begin
                      next_r.rx = 1'b0;
                      next_r.st = ST_START;
                      next_r.sh = make_dab(DEV_ADDR, 1'b0);
                      next_r.ph = PH_DABW;
                    end
                  end
                  default: next_r.st = ST_STOP;
                endcase
              end
            end
          endcase
        end
      endcase
    end
  end

  // ****************************************************************
  // State register
  // ****************************************************************
  always_ff @(posedge core_clk_i) begin
    if (!resetn_i) begin
      r <= HOST_RESET;
    end else begin
      r <= next_r;
    end
  end

  // Pin levels stay low; only the enables move, so nothing ever drives high.
  assign serial_clock_pin_o    = r.line_lvl;
  assign serial_clock_pin_oe_o = r.scl_oe;
  assign serial_data_pin_o     = r.line_lvl;
  assign serial_data_pin_oe_o  = r.sda_oe;
  assign reg_rdata_o           = r.rdata;

endmodule

/* verilog/sercon_pkg.sv */
// Purpose: Shared constants, types and helpers for the serial control port host.
// Assumes: 25 MHz core clock, one open-drain data line and one open-drain clock line.
// Notes:   Register offsets below belong to the host's own command port.

package sercon_pkg;

  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int CLK_PERIOD_NS     = 40;
  localparam int MAX_BIT_RATE_KBPS = 400;
  localparam int BIT_TIME_NS       = 1000000 / MAX_BIT_RATE_KBPS;
  // A bit is four quarters; rounding up keeps the bit rate at or below the limit.
  localparam int QUARTER_CYCLES    = (BIT_TIME_NS + 4 * CLK_PERIOD_NS - 1) / (4 * CLK_PERIOD_NS);

  // ****************************************************************
  // Link constants
  // ****************************************************************
  localparam logic [6:0] DEV_ADDR_DEFAULT = 7'h75;
  localparam int         RAB_FIXED_BIT    = 7;
  localparam int         RAB_STEP_BIT     = 6;
  localparam logic [5:0] ADDR_REG_LOC     = 6'h3f;
  localparam logic [5:0] LAST_READ_LOC    = 6'h2a;
  localparam logic [3:0] ACK_BIT_INDEX    = 4'h8;

  // ****************************************************************
  // Command port map
  // ****************************************************************
  localparam int         REG_ADDR_W    = 4;
  localparam int         BUF_DEPTH     = 8;
  localparam logic [3:0] BUF_DEPTH_CNT = 4'h8;
  localparam logic [3:0] REG_CTRL      = 4'h0;
  localparam logic [3:0] REG_PTR       = 4'h1;
  localparam logic [3:0] REG_COUNT     = 4'h2;
  localparam logic [3:0] REG_STATUS    = 4'h3;
  localparam int         BUF_SEL_BIT   = 3;
  localparam int         CTRL_GO_BIT   = 0;
  localparam int         CTRL_RW_BIT   = 1;
  localparam int         CTRL_STEP_BIT = 2;
  localparam int         STAT_BUSY_BIT = 0;
  localparam int         STAT_DONE_BIT = 1;
  localparam int         STAT_NACK_BIT = 2;

  // ****************************************************************
  // Types
  // ****************************************************************
  typedef enum logic [1:0] {ST_IDLE, ST_START, ST_BIT, ST_STOP} line_state_t;
  typedef enum logic [2:0] {PH_DABW, PH_RAB, PH_DATAW, PH_DABR, PH_DATAR} phase_t;

  typedef struct packed {
    line_state_t                st;
    logic [1:0]                 q;
    logic [3:0]                 bitn;
    logic [7:0]                 sh;
    phase_t                     ph;
    logic                       rx;
    logic                       ack_out;
    logic                       acked;
    logic [3:0]                 left;
    logic [2:0]                 idx;
    logic [5:0]                 ptr;
    logic                       rw;
    logic                       step;
    logic [3:0]                 count;
    logic                       busy;
    logic                       done;
    logic                       nack;
    logic                       scl_oe;
    logic                       sda_oe;
    logic                       line_lvl;
    logic [7:0]                 rdata;
    logic [BUF_DEPTH-1:0][7:0]  bufm;
  } host_state_t;

  localparam host_state_t HOST_RESET = '0;

  // ****************************************************************
  // Helpers
  // ****************************************************************
  function automatic logic [7:0] make_rab(input logic step, input logic [5:0] ptr);
    logic [7:0] b;
    b = {2'b10, ptr};
    b[RAB_STEP_BIT] = step;
    return b;
  endfunction

  function automatic logic [7:0] make_dab(input logic [6:0] dev, input logic rd);
    return {dev, rd};
  endfunction

endpackage

/* verilog/tick_gen.sv */
// Purpose: Quarter-bit tick generator for the serial line sequencer.
// Assumes: QUARTER is at least one cycle.
// Notes:   The count restarts whenever run_i falls, so each frame starts aligned.

`timescale 1ns/1ps

module tick_gen #(
  parameter int QUARTER = 16
) (
  // Clock and reset
  input  wire logic core_clk_i,
  input  wire logic resetn_i,
  // Control and tick
  input  wire logic run_i,
  output logic      tick_o
);

  localparam int CW = $clog2(QUARTER + 1);

  typedef struct packed {
    logic [CW-1:0] cnt;
    logic          tick;
  } tick_t;

  tick_t r;
  tick_t next_r;

  always_comb begin
    next_r      = r;
    next_r.tick = 1'b0;
    if (!run_i) begin
      next_r.cnt = '0;
    end else if (r.cnt == CW'(QUARTER - 1)) begin
      next_r.cnt  = '0;
      next_r.tick = 1'b1;
    end else begin
      next_r.cnt = r.cnt + CW'(1);
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (!resetn_i) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end

  assign tick_o = r.tick;

endmodule
